// >>> verif/program_memory_self_read_ctrl_monitor.sv
/* Checker for the program memory self-read controller.
   Sees only the top ports; bound at the foot of this file. */
`timescale 1ns/10ps
`default_nettype none
module program_memory_self_read_ctrl_monitor
  import progmem_access_pkg::*;
#(parameter int mem_words = memory_words)
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [$clog2(mem_words)-1:0] mem_address, // Word address
  input wire logic mem_read, // Fetch strobe
  input wire logic [word_width-1:0] mem_read_data, // Fetched word
  input wire logic mem_write, // Write start
  input wire logic [word_width-1:0] mem_write_data, // Word to store
  input wire logic mem_write_done, // Write end
  input wire logic instr_discard, // Discard
  input wire logic instr_tick // Cycle end
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read access phase
  logic rd;
  assign rd = psel && penable && !pwrite;
  // Last clock of the stolen cycle
  sequence fetch_end;
    mem_read && instr_tick;
  endsequence
  // Stolen cycle is one whole instruction
  sequence fetch_body;
    mem_read[*4] ##1 !mem_read;
  endsequence
  a_read_upper_zero: assert property (rd |-> prdata[31:8] == '0)
    else $error("upper read bits set");
  a_data_high_mask: assert property (rd && paddr == data_high_offset |-> prdata[7:6] == 2'h0)
    else $error("high data bits 7-6 set");
  a_addr_high_mask: assert property (rd && paddr == address_high_offset |-> prdata[7:3] == 5'h00)
    else $error("high address upper bits set");
  a_control_fixed: assert property (rd && paddr == access_control_offset |-> prdata[7:3] == 5'h10)
    else $error("control fixed bits wrong");
  a_unlock_zero: assert property (rd && paddr == unlock_port_offset |-> prdata == '0)
    else $error("unlock port not zero");
  a_fetch_length: assert property ($rose(mem_read) |-> $past(instr_tick) ##0 fetch_body)
    else $error("fetch cycle misplaced");
  a_discard_with_fetch: assert property (mem_read == instr_discard)
    else $error("discard not with fetch");
  a_fetch_loads_word: assert property (fetch_end |-> ##2 mem_write_data == $past(mem_read_data, 2))
    else $error("fetched word not loaded");
  a_tick_period: assert property (instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("tick period wrong");
  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("ready low in access");
  a_unmapped_error: assert property (psel && penable && paddr > unlock_port_offset |-> pslverr)
    else $error("no error on unmapped");
  a_write_pulse: assert property (mem_write |=> !mem_write)
    else $error("write start too long");
endmodule // program_memory_self_read_ctrl_monitor
bind program_memory_self_read_ctrl program_memory_self_read_ctrl_monitor
  #(.mem_words(mem_words)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mem_address(mem_address), .mem_read(mem_read),
  .mem_read_data(mem_read_data), .mem_write(mem_write), .mem_write_data(mem_write_data),
  .mem_write_done(mem_write_done), .instr_discard(instr_discard), .instr_tick(instr_tick));
`default_nettype wire

// >>> verif/program_memory_self_read_ctrl_tb.sv
/* Testbench: drives APB and the flash side by hand.
   Flash answers each word address with 3'h5 over the address. */
`timescale 1ns/10ps
`default_nettype none
module program_memory_self_read_ctrl_tb;
  import progmem_access_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic pready, pslverr, mem_read, mem_write, instr_discard, instr_tick;
  logic [10:0] mem_address;
  logic [13:0] mem_read_data = 14'h0000, mem_write_data;
  logic mem_write_done = 1'b0;
  int err_total = 0, n_compared = 0;
  program_memory_self_read_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_address(mem_address), .mem_read(mem_read),
    .mem_read_data(mem_read_data), .mem_write(mem_write), .mem_write_data(mem_write_data),
    .mem_write_done(mem_write_done), .instr_discard(instr_discard), .instr_tick(instr_tick));
  // Clock
  initial
  begin
    forever #4 pclk = ~pclk;
  end
  // Flash model: word derived from its address
  always @(posedge pclk) mem_read_data <= {3'h5, mem_address};
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  // One APB transfer, waiting for ready with no bound of its own
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets its answer
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask
  task automatic t_reset;
    rdc(data_low_offset, 32'h0000_0000);
    rdc(data_high_offset, 32'h0000_0000);
    rdc(address_low_offset, 32'h0000_0000);
    rdc(address_high_offset, 32'h0000_0000);
    rdc(access_control_offset, 32'h0000_0080);
  endtask
  task automatic t_fields;
    apb(1'b1, data_low_offset, 32'hFFFF_FFA5);
    rdc(data_low_offset, 32'h0000_00A5);
    apb(1'b1, data_high_offset, 32'hFFFF_FFFF);
    rdc(data_high_offset, 32'h0000_003F);
    apb(1'b1, address_low_offset, 32'h0000_005A);
    rdc(address_low_offset, 32'h0000_005A);
    apb(1'b1, address_high_offset, 32'hFFFF_FFFF);
    rdc(address_high_offset, 32'h0000_0007);
    apb(1'b1, access_control_offset, 32'h0000_007C);
    rdc(access_control_offset, 32'h0000_0084);
    apb(1'b1, unlock_port_offset, 32'hFFFF_FFFF);
    rdc(unlock_port_offset, 32'h0000_0000);
    rdc(8'h18, 32'h0000_0000);
    chk({31'h0000_0000, pslverr}, 32'h0000_0001);
  endtask
  // Load address, trigger, try to clear, poll, read the word
  task automatic t_fetch(input logic [10:0] a);
    int n;
    int ticks;
    int discards;
    apb(1'b1, address_high_offset, {29'h0000_0000, a[10:8]});
    apb(1'b1, address_low_offset, {24'h00_0000, a[7:0]});
    apb(1'b1, access_control_offset, 32'h0000_0001);
    fork
      begin
        // Zero write while the fetch is pending, then one early look
        apb(1'b1, access_control_offset, 32'h0000_0000);
        apb(1'b0, access_control_offset, 32'h0000_0000);
        chk(r, 32'h0000_0081);
      end
      begin
        // Count instruction ends from the trigger edge to the stolen cycle
        ticks = 0;
        discards = 0;
        while (mem_read !== 1'b1)
        begin
          if (instr_tick === 1'b1)
            ticks++;
          if (instr_discard === 1'b1)
            discards++;
          @(posedge pclk);
        end
        chk(ticks, 32'h0000_0002);
        chk(discards, 32'h0000_0000);
        chk({31'h0000_0000, instr_discard}, 32'h0000_0001);
      end
    join
    chk({21'h00_0000, mem_address}, {21'h00_0000, a});
    n = 0;
    do apb(1'b0, access_control_offset, 32'h0000_0000); while (r[0] !== 1'b0 && ++n < 10);
    chk(r, 32'h0000_0080);
    rdc(data_low_offset, {24'h00_0000, a[7:0]});
    rdc(data_high_offset, {26'h000_0000, 3'h5, a[10:8]});
  endtask
  // Write trigger: refused without permit, cannot be cleared
  task automatic t_write;
    apb(1'b1, access_control_offset, 32'h0000_0002);
    @(negedge pclk);
    chk({31'h0000_0000, mem_write}, 32'h0000_0000);
    rdc(access_control_offset, 32'h0000_0080);
    // Permit first; the trigger acts on the permit already stored
    apb(1'b1, access_control_offset, 32'h0000_0004);
    apb(1'b1, access_control_offset, 32'h0000_0006);
    @(negedge pclk);
    chk({31'h0000_0000, mem_write}, 32'h0000_0001);
    chk({18'h0_0000, mem_write_data}, 32'h0000_2AA5);
    rdc(access_control_offset, 32'h0000_0086);
    apb(1'b1, access_control_offset, 32'h0000_0004);
    rdc(access_control_offset, 32'h0000_0086);
    @(posedge pclk) mem_write_done <= 1'b1;
    @(posedge pclk) mem_write_done <= 1'b0;
    rdc(access_control_offset, 32'h0000_0084);
  endtask
  task automatic print_verdict;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (5000) @(posedge pclk);
    err_total++;
    print_verdict;
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_fields;
    t_fetch(11'h7FF);
    t_fetch(11'h2A5);
    t_write;
    print_verdict;
  end
endmodule // program_memory_self_read_ctrl_tb
`default_nettype wire

// >>> verilog/progmem_access_pkg.sv
/*
  Shared constants for the program memory self-read controller:
  register offsets, field positions, reset values and widths.
  Assumes a 32-bit APB register bus with one byte register per aligned word.
*/
package progmem_access_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] data_low_offset = 8'h00;
  localparam logic [7:0] data_high_offset = 8'h04;
  localparam logic [7:0] address_low_offset = 8'h08;
  localparam logic [7:0] address_high_offset = 8'h0C;
  localparam logic [7:0] access_control_offset = 8'h10;
  localparam logic [7:0] unlock_port_offset = 8'h14;

  // Field widths of the word and address registers
  localparam int data_high_width = 6;
  localparam int address_high_width = 3;
  localparam int word_width = 14;
  localparam int address_width = 13;

  // Access control field positions
  localparam int ctrl_fixed_one_bit = 7;
  localparam int ctrl_permit_bit = 2;
  localparam int ctrl_write_bit = 1;
  localparam int ctrl_read_bit = 0;

  // Reset values
  localparam logic [7:0] data_low_reset = 8'h00;
  localparam logic [5:0] data_high_reset = 6'h00;
  localparam logic [7:0] address_low_reset = 8'h00;
  localparam logic [2:0] address_high_reset = 3'h0;

  // Timing: clock cycles that make one processor instruction cycle
  localparam int clocks_per_instruction = 4;

  // Implemented program memory: 2K words
  localparam int memory_words = 2048;

  // Controller states
  typedef enum logic [1:0] {
    idle_state,
    skip_state,
    access_state,
    write_state
  } control_state_type;

endpackage : progmem_access_pkg

// >>> verilog/program_memory_self_read_ctrl.sv
/*
  Program memory self-read controller, APB register slave.
  Holds the address and data byte registers and the access control register;
  starts a one-cycle program word fetch in the second instruction cycle after
  the read trigger, and write cycles gated by the write permit bit.
  Assumes the flash array answers a fetch within one instruction cycle and
  signals write completion with a same-clock pulse; the processor core
  discards its instruction while instr_discard is high.
*/
`timescale 1ns/10ps
`default_nettype none

module program_memory_self_read_ctrl
  import progmem_access_pkg::*;
#(
  parameter int instr_clocks = progmem_access_pkg::clocks_per_instruction, // Clocks per instr
  parameter int mem_words = progmem_access_pkg::memory_words // Implemented words
)
(
  input wire logic pclk, // APB clock, 125 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic [$clog2(mem_words)-1:0] mem_address, // Flash word address
  output logic mem_read, // Flash fetch strobe, access cycle
  input wire logic [progmem_access_pkg::word_width-1:0] mem_read_data, // Fetched word
  output logic mem_write, // Flash write start pulse
  output logic [progmem_access_pkg::word_width-1:0] mem_write_data, // Word to store
  input wire logic mem_write_done, // Flash write finished pulse
  output logic instr_discard, // Core discards current instruction
  output logic instr_tick // Last clock of each instruction cycle
);

  import progmem_access_pkg::*;

  localparam int mem_address_width = $clog2(mem_words);
  localparam int tick_width = $clog2(instr_clocks + 1);

  // Register storage
  logic [7:0] data_low; // Low data byte
  logic [data_high_width-1:0] data_high; // High data bits
  logic [7:0] address_low; // Low address byte
  logic [address_high_width-1:0] address_high; // High address bits
  logic store_permit; // Write permit bit
  logic write_trigger; // Write in progress bit
  logic read_trigger; // Fetch in progress bit

  // Sequencing
  control_state_type state; // Controller state
  logic [tick_width-1:0] tick_count; // Instruction cycle divider
  logic tick; // One-clock end of instruction cycle
  logic skip_more; // Setting instruction has not ended yet

  // Bus decode
  logic setup_phase; // APB setup cycle
  logic write_access; // APB write takes effect
  logic known_address; // Address hits a register
  logic [7:0] read_mux; // Byte selected for read
  logic [address_width-1:0] full_address; // Thirteen-bit word address

  assign setup_phase = psel && !penable;
  assign write_access = psel && penable && pready && pwrite;
  // The two top address bits are not implemented and stay zero
  assign full_address = {2'h0, address_high, address_low};

  // Instruction cycle divider: one-cycle enable at the end of each cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_count <= '0;
      tick <= 1'b0;
    end
    else if (tick_count == tick_width'(instr_clocks - 1))
    begin
      tick_count <= '0;
      tick <= 1'b1;
    end
    else
    begin
      tick_count <= tick_count + tick_width'(1);
      tick <= 1'b0;
    end
  end

  // Tick presented to the core from its flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      instr_tick <= 1'b0;
    else
      instr_tick <= (tick_count == tick_width'(instr_clocks - 1));
  end

  // Read mux; unimplemented bits read as zero, bit 7 of control reads one
  always_comb
  begin
    read_mux = 8'h00;
    known_address = 1'b1;
    unique case (paddr)
      data_low_offset: read_mux = data_low;
      data_high_offset: read_mux = {2'b00, data_high};
      address_low_offset: read_mux = address_low;
      address_high_offset: read_mux = {5'b0_0000, address_high};
      access_control_offset:
      begin
        read_mux[ctrl_fixed_one_bit] = 1'b1;
        read_mux[ctrl_permit_bit] = store_permit;
        read_mux[ctrl_write_bit] = write_trigger;
        read_mux[ctrl_read_bit] = read_trigger;
      end
      unlock_port_offset: read_mux = 8'h00;
      default: known_address = 1'b0;
    endcase
  end

  // APB answer: zero wait, data and error prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup_phase)
      begin
        prdata <= {24'h00_0000, read_mux};
        pslverr <= !known_address;
      end
    end
  end

  // Address registers, software only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      address_low <= address_low_reset;
      address_high <= address_high_reset;
    end
    else if (write_access)
    begin
      // Software is expected to finish both bytes before the trigger
      if (paddr == address_low_offset)
        address_low <= pwdata[7:0];
      if (paddr == address_high_offset)
        address_high <= pwdata[address_high_width-1:0];
    end
  end

  // Data registers: loaded by a completed fetch, otherwise by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_low <= data_low_reset;
      data_high <= data_high_reset;
    end
    else if (state == access_state && tick)
    begin
      // Fetch wins over a software write landing on the same edge
      data_low <= mem_read_data[7:0];
      data_high <= mem_read_data[word_width-1:8];
    end
    else if (write_access)
    begin
      // Otherwise a software write loads the addressed byte
      if (paddr == data_low_offset)
        data_low <= pwdata[7:0];
      if (paddr == data_high_offset)
        data_high <= pwdata[data_high_width-1:0];
    end
  end

  // Write permit, plain read and write bit, clear at power-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      store_permit <= 1'b0;
    else if (write_access && paddr == access_control_offset)
      store_permit <= pwdata[ctrl_permit_bit];
  end

  // Controller: trigger bits, fetch timing and write cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= idle_state;
      read_trigger <= 1'b0;
      write_trigger <= 1'b0;
      skip_more <= 1'b0;
    end
    else
    begin
      unique case (state)
        idle_state:
        begin
          // Zeros written to the triggers do nothing; only a one acts
          if (write_access && paddr == access_control_offset)
          begin
            if (pwdata[ctrl_read_bit])
            begin
              read_trigger <= 1'b1;
              // Mid-instruction trigger must first see its own instruction end
              skip_more <= !tick;
              state <= skip_state;
            end
            else if (pwdata[ctrl_write_bit] && store_permit)
            begin
              write_trigger <= 1'b1;
              state <= write_state;
            end
          end
        end
        skip_state:
        begin
          // First following instruction runs normally
          if (tick)
          begin
            if (skip_more)
              skip_more <= 1'b0; // Setting instruction ends here
            else
              state <= access_state;
          end
        end
        access_state:
        begin
          // Word captured at the end of the stolen cycle
          if (tick)
          begin
            read_trigger <= 1'b0;
            state <= idle_state;
          end
        end
        write_state:
        begin
          // A running write cannot be aborted by software
          if (mem_write_done)
          begin
            write_trigger <= 1'b0;
            state <= idle_state;
          end
        end
      endcase
    end
  end

  // Flash side: address, fetch strobe and discard for the stolen cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_address <= '0;
      mem_read <= 1'b0;
      instr_discard <= 1'b0;
    end
    else
    begin
      // Only the implemented 2K words are addressed
      mem_address <= full_address[mem_address_width-1:0];
      if (tick)
      begin
        // Steal the cycle once the first following instruction has ended
        mem_read <= state == skip_state && !skip_more;
        instr_discard <= state == skip_state && !skip_more;
      end
    end
  end

  // Write start pulse with the word to store
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_write <= 1'b0;
      mem_write_data <= '0;
    end
    else
    begin
      mem_write <= state == idle_state && write_access &&
                   paddr == access_control_offset && !pwdata[ctrl_read_bit] &&
                   pwdata[ctrl_write_bit] && store_permit;
      mem_write_data <= {data_high, data_low};
    end
  end

endmodule // program_memory_self_read_ctrl

`default_nettype wire
